// [design/mismatch_pkg.sv]
package mismatch_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned TICK_US      = 100;   // Timebase tick period
  localparam int unsigned TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int unsigned TICK_W       = 14;
  localparam int unsigned STRETCH_MS   = 500;
  localparam int unsigned REDUCE_MS    = 47;
  localparam int unsigned TEST_MS      = 10;
  localparam int unsigned CLR_US       = 500;
  localparam int unsigned CLK_NS       = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned STRETCH_TICKS = STRETCH_MS * 1000 / TICK_US;
  localparam int unsigned REDUCE_TICKS  = REDUCE_MS * 1000 / TICK_US;
  localparam int unsigned TEST_TICKS    = TEST_MS * 1000 / TICK_US;
  localparam int unsigned CLR_TICKS     = CLR_US / TICK_US;
  localparam int unsigned CLK_DLY_CYC   = CLK_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W        = 13;
  localparam int unsigned ACC_W        = 12;
  // Accumulator: +1 per 100 us tick of hit, -1 every 400 us without; threshold 2500 ticks (250 ms)
  localparam logic [ACC_W-1:0] ACC_MAX    = 12'h0_FFF;
  localparam logic [ACC_W-1:0] ACC_THRESH = 12'h0_9C4;
  localparam logic [1:0] DECAY_DIV = 2'h3;  // Decay every fourth tick
  localparam int unsigned NTYPE = 2;        // 0 filter, 1 antenna

  typedef struct packed {
    logic filter;
    logic antenna;
  } mis_pair_s;
endpackage

// [design/retrig_oneshot.sv]
`timescale 1ns/1ps
// Retriggerable tick-counted one-shot
module retrig_oneshot
  import mismatch_pkg::*;
#(
  parameter logic [CNT_W-1:0] LEN = 13'h0_001
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic tick,
  input  wire logic inhibit,
  input  wire logic trig,
  output logic      active
);
  logic [CNT_W-1:0] cnt;
  wire  logic       run = (cnt != '0);

  // Load on trigger, count down on tick
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt    <= '0;
      active <= 1'b0;
    end else if (ce) begin
      if (inhibit) begin
        cnt    <= '0;
        active <= 1'b0;
      end else if (trig) begin
        cnt    <= LEN;  // restart extends
        active <= 1'b1;
      end else if (tick && run) begin
        cnt    <= cnt - 1'b1;
        active <= (cnt != LEN - (LEN - 13'h0_001));
      end
    end
  end
endmodule // retrig_oneshot

// [design/mismatch_fault_logic.sv]
`timescale 1ns/1ps
module mismatch_fault_logic
  import mismatch_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic filter_hit_n,
  input  wire logic antenna_hit_n,
  input  wire logic supply_ok_n,
  input  wire logic manual_test_n,
  input  wire logic status_reset,
  input  wire logic [ACC_W-1:0] acc_thresh,
  output logic      hit_combined_n,
  output logic      amp_shutdown_req,
  output logic      drive_changeover_pulse,
  output mis_pair_s mismatch_status_out,
  output mis_pair_s ind_green,
  output mis_pair_s ind_red,
  output logic      mismatch_power_reduce,
  output logic      type3_fault_out,
  output logic      selftest_pulse_n,
  output logic      selftest_fail_out,
  output logic      selftest_green,
  output logic      selftest_red
);
  import mismatch_pkg::*;

  // Input synchronisers
  logic [3:0] s1, s2;
  logic       sup_q, man_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 4'hB;  // Supply seen as settling until sampled, no false power-up start
      s2 <= 4'hB;
    end else if (ce) begin
      s1 <= {manual_test_n, supply_ok_n, antenna_hit_n, filter_hit_n};
      s2 <= s1;
    end
  end

  // Active-high hit pulses with filter inhibited when both present
  wire logic fil_raw = ~s2[0];
  wire logic ant_raw = ~s2[1];
  wire logic both    = fil_raw & ant_raw;
  wire logic fil_hit = fil_raw & ~both;
  wire logic ant_hit = ant_raw;          // not gated, antenna kept when both present
  wire logic any_hit = fil_hit | ant_hit;
  wire logic settling = ~s2[2];
  wire logic man_now  = s2[3];

  // Timebase tick
  logic [TICK_W-1:0] tdiv;
  logic              tick;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tdiv <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= (tdiv == TICK_W'(TICK_CYC - 1));
      tdiv <= (tdiv == TICK_W'(TICK_CYC - 1)) ? '0 : tdiv + 1'b1;
    end
  end

  // Edge history
  logic fil_d, ant_d, any_d;
  wire  logic fil_rise = fil_hit & ~fil_d;
  wire  logic ant_rise = ant_hit & ~ant_d;
  wire  logic any_rise = any_hit & ~any_d;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fil_d <= 1'b0;
      ant_d <= 1'b0;
      any_d <= 1'b0;
      sup_q <= 1'b0;
      man_q <= 1'b1;
    end else if (ce) begin
      fil_d <= fil_hit;
      ant_d <= ant_hit;
      any_d <= any_hit;
      sup_q <= ~settling;
      man_q <= man_now;
    end
  end

  // Combined hit, shutdown and changeover
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hit_combined_n         <= 1'b1;
      amp_shutdown_req       <= 1'b0;
      drive_changeover_pulse <= 1'b0;
    end else if (ce) begin
      hit_combined_n         <= ~any_hit;
      amp_shutdown_req       <= any_hit;
      drive_changeover_pulse <= any_rise;
    end
  end

  // Per-type stretcher, accumulator, latch
  wire logic [NTYPE-1:0] hit_v  = {ant_hit, fil_hit};
  wire logic [NTYPE-1:0] rise_v = {ant_rise, fil_rise};
  logic [NTYPE-1:0] stretch, multi, multi_d, latch, gated;
  logic [1:0]       dphase;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) dphase <= '0;
    else if (ce && tick) dphase <= dphase + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < NTYPE; g++) begin : g_type
      logic [ACC_W-1:0] acc;
      retrig_oneshot #(.LEN(CNT_W'(STRETCH_TICKS))) u_stretch (
        .mclk   (mclk),
        .nrst   (nrst),
        .ce     (ce),
        .tick   (tick),
        .inhibit(settling),
        .trig   (rise_v[g]),
        .active (stretch[g])
      );
      // Saturating leaky accumulator
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          acc     <= '0;
          multi   [g] <= 1'b0;
          multi_d [g] <= 1'b0;
          latch   [g] <= 1'b0;
        end else if (ce) begin
          if (tick && hit_v[g] && acc != ACC_MAX)
            acc <= acc + 1'b1;
          else if (tick && !hit_v[g] && acc != '0 && dphase == DECAY_DIV)
            acc <= acc - 1'b1;
          multi[g]   <= (acc >= acc_thresh);
          multi_d[g] <= multi[g];
          if (multi[g] && !multi_d[g]) latch[g] <= 1'b1;  // set wins
          else if (status_reset) latch[g] <= 1'b0;
        end
      end
      assign gated[g] = multi[g] & rise_v[g];
    end
  endgenerate

  // Status and indicator outputs
  wire mis_pair_s act = '{filter: stretch[0] | latch[0], antenna: stretch[1] | latch[1]};
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mismatch_status_out <= '0;
      ind_green           <= '1;
      ind_red             <= '0;
    end else if (ce) begin
      mismatch_status_out <= act;
      ind_green           <= ~act;
      ind_red             <= act;
    end
  end

  // Power reduce one-shot, controller acts while high
  logic reduce_act;
  retrig_oneshot #(.LEN(CNT_W'(REDUCE_TICKS))) u_reduce (
    .mclk   (mclk),
    .nrst   (nrst),
    .ce     (ce),
    .tick   (tick),
    .inhibit(1'b0),
    .trig   (|gated),
    .active (reduce_act)
  );
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mismatch_power_reduce <= 1'b0;
      type3_fault_out       <= 1'b0;
    end else if (ce) begin
      mismatch_power_reduce <= reduce_act;
      type3_fault_out       <= reduce_act;
    end
  end

  // Self-test sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_CLR, ST_CLK, ST_RUN} st_e;
  st_e              st;
  logic [CNT_W-1:0] tcnt;
  logic [3:0]       ccnt;
  logic             pwr_done, result;
  wire  logic       pwr_start = ~settling & ~sup_q ? 1'b0 : (~settling & ~pwr_done);
  wire  logic       man_fall  = man_q & ~man_now;
  wire  logic       start     = (st == ST_IDLE) & (pwr_start | man_fall);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st       <= ST_IDLE;
      tcnt     <= '0;
      ccnt     <= '0;
      pwr_done <= 1'b0;
      result   <= 1'b1;
    end else if (ce) begin
      if (start) pwr_done <= 1'b1;
      case (st)
        ST_IDLE: begin
          if (start) begin
            st     <= ST_CLR;
            tcnt   <= '0;
            result <= 1'b0;  // clear
          end
        end
        ST_CLR: begin
          if (tick) tcnt <= tcnt + 1'b1;
          if (tcnt == CNT_W'(CLR_TICKS)) begin
            st   <= ST_CLK;
            ccnt <= '0;
          end
        end
        ST_CLK: begin
          if (tick) tcnt <= tcnt + 1'b1;
          ccnt <= ccnt + 1'b1;
          if (ccnt == 4'(CLK_DLY_CYC - 1)) begin
            result <= ~hit_combined_n;
            st     <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) tcnt <= tcnt + 1'b1;
          if (tcnt >= CNT_W'(TEST_TICKS)) st <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Self-test outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      selftest_pulse_n  <= 1'b1;
      selftest_fail_out <= 1'b0;
      selftest_green    <= 1'b0;
      selftest_red      <= 1'b0;
    end else if (ce) begin
      selftest_pulse_n  <= (st == ST_IDLE) & ~start;
      selftest_fail_out <= ~result & (st == ST_IDLE) & pwr_done;
      selftest_green    <= result & (st == ST_IDLE);
      selftest_red      <= ~result;
    end
  end
endmodule // mismatch_fault_logic

// [verif/mismatch_fault_sva.sv]
`timescale 1ns/1ps
module mismatch_fault_sva
  import mismatch_pkg::*;
(
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                filter_hit_n,
  input wire logic                antenna_hit_n,
  input wire logic                supply_ok_n,
  input wire logic                manual_test_n,
  input wire logic                hit_combined_n,
  input wire logic                amp_shutdown_req,
  input wire logic                drive_changeover_pulse,
  input wire mismatch_pkg::mis_pair_s mismatch_status_out,
  input wire mismatch_pkg::mis_pair_s ind_green,
  input wire mismatch_pkg::mis_pair_s ind_red,
  input wire logic                selftest_pulse_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Steps of a hit and of a manual request
  sequence s_any_hit; (!filter_hit_n || !antenna_hit_n)[*4]; endsequence
  sequence s_ant_start;
    supply_ok_n[*4] ##0 $fell(antenna_hit_n) ##1 (supply_ok_n && !antenna_hit_n)[*6];
  endsequence
  sequence s_manual; $fell(manual_test_n); endsequence
  property p_hit; s_any_hit |-> !hit_combined_n; endproperty
  property p_shut; amp_shutdown_req == !hit_combined_n; endproperty
  property p_chg_one; drive_changeover_pulse |=> !drive_changeover_pulse; endproperty
  property p_chg_fire; $fell(hit_combined_n) |-> ##[0:2] drive_changeover_pulse; endproperty
  property p_ind; ind_red == mismatch_status_out && ind_green == ~mismatch_status_out;
  endproperty
  property p_stretch; s_ant_start |-> mismatch_status_out.antenna; endproperty
  property p_sup; !antenna_hit_n[*8] |-> !$rose(mismatch_status_out.filter); endproperty
  property p_man; s_manual |-> ##[1:5] !selftest_pulse_n; endproperty
  property p_stpulse; $fell(selftest_pulse_n) |-> !selftest_pulse_n[*8]; endproperty
  a_hit: assert property (p_hit) else $error("combined hit not low");
  a_shut: assert property (p_shut) else $error("shutdown differs from hit");
  a_chg_one: assert property (p_chg_one) else $error("changeover too long");
  a_chg_fire: assert property (p_chg_fire) else $error("changeover missing");
  a_ind: assert property (p_ind) else $error("indicator mismatch");
  a_stretch: assert property (p_stretch) else $error("stretcher not fired");
  a_sup: assert property (p_sup) else $error("filter not suppressed");
  a_man: assert property (p_man) else $error("manual test not started");
  a_stpulse: assert property (p_stpulse) else $error("test pulse too short");
endmodule // mismatch_fault_sva
bind mismatch_fault_logic mismatch_fault_sva i_sva (
  .mclk(mclk), .nrst(nrst), .filter_hit_n(filter_hit_n), .antenna_hit_n(antenna_hit_n),
  .supply_ok_n(supply_ok_n), .manual_test_n(manual_test_n), .hit_combined_n(hit_combined_n),
  .amp_shutdown_req(amp_shutdown_req), .drive_changeover_pulse(drive_changeover_pulse),
  .mismatch_status_out(mismatch_status_out), .ind_green(ind_green), .ind_red(ind_red),
  .selftest_pulse_n(selftest_pulse_n));

// [verif/monitor_model.sv]
`timescale 1ns/1ps
// Output monitor: detector pulses on command, simulated hit on test pulse
module monitor_model #(
  parameter int ST_LEN = 40,
  parameter int ST_DLY = 4
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic cmd_f,
  input  wire logic cmd_a,
  input  wire logic selftest_pulse_n,
  input  wire logic power_reduce,
  output logic      filter_hit_n,
  output logic      antenna_hit_n
);
  int   st_cnt;
  int   power_step;
  logic pulse_q;
  // Controller side: keep stepping power down while the reduce command stands
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) power_step <= 0;
    else if (power_reduce) power_step <= power_step + 1;
  end
  // Simulated hit on both detectors, a few cycles after the test pulse falls
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_cnt  <= 0;
      pulse_q <= 1'b1;
    end else begin
      pulse_q <= selftest_pulse_n;
      if (pulse_q && !selftest_pulse_n) st_cnt <= ST_LEN + ST_DLY;
      else if (st_cnt > 0) st_cnt <= st_cnt - 1;
    end
  end
  assign filter_hit_n  = !(cmd_f || (st_cnt > 0 && st_cnt <= ST_LEN));
  assign antenna_hit_n = !(cmd_a || (st_cnt > 0 && st_cnt <= ST_LEN));
endmodule // monitor_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import mismatch_pkg::*;
  logic mclk, nrst, ce, supply_ok_n, manual_test_n, status_reset, cmd_f, cmd_a;
  logic filter_hit_n, antenna_hit_n, hit_combined_n, amp_shutdown_req, drive_changeover_pulse;
  logic mismatch_power_reduce, type3_fault_out, selftest_pulse_n, selftest_fail_out;
  logic selftest_green, selftest_red;
  logic [ACC_W-1:0] acc_thresh;
  mis_pair_s mismatch_status_out, ind_green, ind_red;
  int n_fail, cmp_count, npulse;
  mismatch_fault_logic i_dut (.mclk(mclk), .nrst(nrst), .ce(ce), .filter_hit_n(filter_hit_n),
    .antenna_hit_n(antenna_hit_n), .supply_ok_n(supply_ok_n), .manual_test_n(manual_test_n),
    .status_reset(status_reset), .acc_thresh(acc_thresh), .hit_combined_n(hit_combined_n),
    .amp_shutdown_req(amp_shutdown_req), .drive_changeover_pulse(drive_changeover_pulse),
    .mismatch_status_out(mismatch_status_out), .ind_green(ind_green), .ind_red(ind_red),
    .mismatch_power_reduce(mismatch_power_reduce), .type3_fault_out(type3_fault_out),
    .selftest_pulse_n(selftest_pulse_n), .selftest_fail_out(selftest_fail_out),
    .selftest_green(selftest_green), .selftest_red(selftest_red));
  monitor_model i_mon (.mclk(mclk), .nrst(nrst), .cmd_f(cmd_f), .cmd_a(cmd_a),
    .selftest_pulse_n(selftest_pulse_n), .power_reduce(mismatch_power_reduce),
    .filter_hit_n(filter_hit_n), .antenna_hit_n(antenna_hit_n));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Compare at a settled point
  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    n_fail = 0; cmp_count = 0; nrst = 1'b0; ce = 1'b1; supply_ok_n = 1'b0;
    manual_test_n = 1'b1; status_reset = 1'b0; cmd_f = 1'b0; cmd_a = 1'b0;
    acc_thresh = 12'h09C4;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    wait_n(1);
    chk("hit_combined_n", 1, hit_combined_n);
    chk("ind_green", 2'b11, ind_green);
    chk("status", 2'b00, mismatch_status_out);
    chk("selftest_pulse_n", 1, selftest_pulse_n);
    chk("power_reduce", 0, mismatch_power_reduce);
    $display("test reset done");
    @(posedge mclk) cmd_f <= 1'b1;
    wait_n(8);
    chk("hit_combined_n", 0, hit_combined_n);
    chk("amp_shutdown_req", 1, amp_shutdown_req);
    chk("status", 2'b00, mismatch_status_out);
    @(posedge mclk) cmd_f <= 1'b0;
    wait_n(8);
    chk("hit_combined_n", 1, hit_combined_n);
    $display("test settling done");
    @(posedge mclk) supply_ok_n <= 1'b1;
    wait_n(8);
    chk("selftest_pulse_n", 0, selftest_pulse_n);
    wait_n(20);
    chk("hit_combined_n", 0, hit_combined_n);
    chk("status", 2'b01, mismatch_status_out);
    chk("ind_red", 2'b01, ind_red);
    chk("ind_green", 2'b10, ind_green);
    wait_n(40);
    chk("hit_combined_n", 1, hit_combined_n);
    chk("status", 2'b01, mismatch_status_out);
    $display("test power-up done");
    npulse = 0;
    @(posedge mclk) cmd_f <= 1'b1;
    repeat (20) begin
      @(negedge mclk);
      npulse += int'(drive_changeover_pulse === 1'b1);
    end
    chk("changeover_count", 2'b01, npulse[1:0]);
    chk("status", 2'b11, mismatch_status_out);
    @(posedge mclk) cmd_f <= 1'b0;
    $display("test filter hit done");
    @(posedge mclk) manual_test_n <= 1'b0;
    wait_n(8);
    chk("selftest_pulse_n", 0, selftest_pulse_n);
    @(posedge mclk) manual_test_n <= 1'b1;
    $display("test manual done");
    @(posedge mclk) supply_ok_n <= 1'b0;
    wait_n(8);
    chk("status", 2'b00, mismatch_status_out);
    chk("ind_green", 2'b11, ind_green);
    $display("test inhibit done");
    @(posedge mclk) acc_thresh <= 12'h0001;
    @(posedge mclk) cmd_a <= 1'b1;
    wait_n(TICK_CYC + 20);
    chk("status", 2'b01, mismatch_status_out);
    @(posedge mclk) cmd_a <= 1'b0;
    wait_n(8);
    @(posedge mclk) cmd_a <= 1'b1;
    wait_n(8);
    chk("power_reduce", 1, mismatch_power_reduce);
    chk("type3_fault_out", 1, type3_fault_out);
    @(posedge mclk) cmd_a <= 1'b0;
    @(posedge mclk) status_reset <= 1'b1;
    @(posedge mclk) status_reset <= 1'b0;
    wait_n(4);
    chk("status", 2'b00, mismatch_status_out);
    $display("test multiple hit done");
    report_and_stop();
  end
endmodule // tb_top
